// [dua_pkg.sv]
// Shared constants and types for the upstream D-channel arbiter.
// Assumes an IOM-2 TE frame of 12 octet timeslots, one data bit per link bit clock.
package dua_pkg;

  // Frame geometry: 12 timeslots of 8 bits
  localparam logic [6:0] FRAME_BITS_M1 = 7'h5F;
  // Upstream D bits sit in the first two bits of channel 0, timeslot 3
  localparam logic [6:0] D_POS_FIRST = 7'h18;
  localparam logic [6:0] D_POS_LAST = 7'h19;
  // Bit 5 of the last octet of channel 2, sent third, MSB first
  localparam logic [6:0] SG_POS = 7'h5A;

  // Mode field values that select this application
  localparam logic [1:0] MODE_INT_NT = 2'h3;
  localparam logic [2:0] DIM_SG_EVAL = 3'h1;

  // Consecutive-ones thresholds
  localparam int ONES_W = 4;
  localparam logic [3:0] NEED_P8 = 4'h8;
  localparam logic [3:0] NEED_P8_LOW = 4'h9;
  localparam logic [3:0] NEED_P10 = 4'hA;
  localparam logic [3:0] NEED_P10_LOW = 4'hB;
  localparam logic [3:0] ABORT_ONES = 4'h7;
  localparam logic [3:0] ONES_MAX = 4'hF;

  // Width of one buffered S-bus D word (two D bits per frame)
  localparam int DWORD_W = 2;

  // Static configuration, driven by the register logic around the block
  typedef struct packed {
    logic [2:0] transceiver_mode_field;
    logic [2:0] dchan_interface_mode;
    logic te_frame;
    logic tic_enable;
    logic iom_access_priority;
  } dua_cfg_t;

  // Arbiter states
  typedef enum logic [1:0] {
    ST_READY,
    ST_IDLE,
    ST_BUSY
  } dua_state_t;

endpackage

// [dua_sync.sv]
// Two-flop synchroniser for a group of slow pin levels.
// Assumes the inputs come from outside the clk domain and change slowly.
`timescale 1ns/100ps
`default_nettype none
module dua_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r; // First stage, read only by the second
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Next values: plain shift
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Register both stages; pins idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// [dua_fifo.sv]
// Small FIFO of flip-flops with valid/ready on both sides.
// Assumes source and sink share clk; in_ready comes from a flop.
`timescale 1ns/100ps
`default_nettype none
module dua_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // Pointers
  logic [CW-1:0] cnt_r, cnt_nxt; // Fill level
  logic rdy_r, rdy_nxt; // Registered room flag
  logic push, pop;

  // Handshakes; a push is refused while full, so nothing is lost
  assign push = in_valid && rdy_r;
  assign pop = out_ready && (cnt_r != '0);

  // Next-state computation
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    rdy_nxt = (cnt_nxt != CW'(DEPTH));
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign in_ready = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

endmodule
`default_nettype wire

// [dua_arbiter.sv]
// Upstream D-channel arbiter for the intelligent NT application.
// Assumes the IOM-2 bit clock and frame sync arrive on pins from another
// clock domain, and that configuration and permit come from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Both upper mode bits set selects intelligent NT
// - Interface mode 001 enables stop/go evaluation
// - Only active with TE frame and TIC bus
// - Stop/go gates controllers, echo inversion gates terminals
// - Count upstream D ones; zero restarts count
// - Count reached and bus-accessed zero grants access
// - Priority selectable as 8 or 10
// - Permit zero stops all sources, no evaluation
// - Ready sends stop; n ones gives go
// - Inverted echo while IOM source holds channel
// - Bus freed: normal echo and stop again
// - n is 8/10 after abort, 9/11 after success
// - After transmission stop until n ones seen
// - Active S D-channel passes into channel 0
// - Permit one allows D-channel transmission
// - Stop/go written into channel 2 always
// - Bus-accessed bit is bit 5, channel 2 up
// - Stop/go is bit 5, channel 2 down, 1=stop
module dua_arbiter #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and exchange permit
  input wire dua_pkg::dua_cfg_t cfg,
  input wire logic line_permit,
  // IOM-2 timing pins
  input wire logic bit_clk_pin,
  input wire logic frame_sync_pin,
  // Upstream data line, open drain
  input wire logic upstream_data_line_in,
  output logic upstream_data_line_out,
  output logic upstream_data_line_oe_n,
  // Downstream data line, stop/go slot
  output logic downstream_data_line_out,
  output logic downstream_data_line_oe_n,
  // S-bus D-channel side
  input wire logic s_dchan_active,
  input wire logic s_d_valid,
  input wire logic [dua_pkg::DWORD_W-1:0] s_d_data,
  output logic s_d_ready,
  // Status towards the S transceiver
  output logic echo_invert,
  output logic stop_go
);

  // Synchronised pin levels
  logic bclk_s, fsync_s, du_s;
  logic bclk_d_r, bclk_d_nxt; // Previous bit clock level for edge finding
  logic rise, fall;

  // Frame position
  logic [6:0] pos_r, pos_nxt;

  // Arbiter state
  dua_pkg::dua_state_t state_r, state_nxt;
  logic [dua_pkg::ONES_W-1:0] ones_r, ones_nxt; // Consecutive ones
  logic [dua_pkg::ONES_W-1:0] ones_inc; // Count after this D bit
  logic low_r, low_nxt; // Lower priority level after success
  logic abort_r, abort_nxt; // Abort seen during current hold
  logic echo_r, echo_nxt;
  logic sg_r, sg_nxt;

  // Pin drive registers
  logic du_out_r, du_out_nxt, du_oe_n_r, du_oe_n_nxt;
  logic dd_out_r, dd_out_nxt, dd_oe_n_r, dd_oe_n_nxt;

  // Decoded conditions
  logic arb_en, d_sample, bac_sample, pass_s;
  logic [dua_pkg::ONES_W-1:0] need;
  logic sg_now;

  // Buffer between S-bus D data and the upstream slot
  logic buf_valid, buf_pop;
  logic [dua_pkg::DWORD_W-1:0] buf_data;

  // Bit clock, frame sync and upstream data all cross from the link
  dua_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({bit_clk_pin, frame_sync_pin, upstream_data_line_in}),
    .q({bclk_s, fsync_s, du_s})
  );

  // Two-entry buffer; the sink only drains in the D slot, so it stalls
  dua_fifo #(
    .WIDTH(dua_pkg::DWORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_d_valid),
    .in_data(s_d_data),
    .in_ready(s_d_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  // Edges of the bit clock: drive on rise, sample on fall
  assign rise = bclk_s && !bclk_d_r;
  assign fall = !bclk_s && bclk_d_r;

  // Arbiter runs only in this exact configuration
  assign arb_en = (cfg.transceiver_mode_field[2:1] == dua_pkg::MODE_INT_NT)
    && (cfg.dchan_interface_mode == dua_pkg::DIM_SG_EVAL)
    && cfg.te_frame && cfg.tic_enable;

  // Sample points in the upstream frame
  assign d_sample = fall && ((pos_r == dua_pkg::D_POS_FIRST) || (pos_r == dua_pkg::D_POS_LAST));
  assign bac_sample = fall && (pos_r == dua_pkg::SG_POS);

  // Required ones: base 8 or 10, one more after a success
  always_comb begin
    if (cfg.iom_access_priority) begin
      need = low_r ? dua_pkg::NEED_P10_LOW : dua_pkg::NEED_P10;
    end else begin
      need = low_r ? dua_pkg::NEED_P8_LOW : dua_pkg::NEED_P8;
    end
  end

  // Ones counter step, saturating; a zero bit restarts it
  always_comb begin
    if (!du_s) begin
      ones_inc = '0;
    end else if (ones_r == dua_pkg::ONES_MAX) begin
      ones_inc = ones_r;
    end else begin
      ones_inc = ones_r + 1'b1;
    end
  end

  // Frame position: frame sync at a rising edge restarts the frame
  always_comb begin
    bclk_d_nxt = bclk_s;
    pos_nxt = pos_r;
    if (rise) begin
      if (fsync_s || (pos_r == dua_pkg::FRAME_BITS_M1)) begin
        pos_nxt = '0;
      end else begin
        pos_nxt = pos_r + 1'b1;
      end
    end
  end

  // Timing registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d_r <= 1'b1; // Matches the synchroniser reset level, so no false edge
      pos_r <= '0;
    end else begin
      bclk_d_r <= bclk_d_nxt;
      pos_r <= pos_nxt;
    end
  end

  // Arbitration: ready, idle (go), busy (an IOM-2 source holds the channel)
  always_comb begin
    state_nxt = state_r;
    ones_nxt = ones_r;
    low_nxt = low_r;
    abort_nxt = abort_r;
    if (!arb_en || !line_permit) begin
      // Blocked: nothing is evaluated, stop stays asserted
      state_nxt = dua_pkg::ST_READY;
      ones_nxt = '0;
      abort_nxt = 1'b0;
    end else begin
      // Permit high, channel may be granted
      if (d_sample) begin
        ones_nxt = ones_inc;
        // A ones count of seven or more, carried on from before the hold, marks an abort inside a hold
        if ((state_r == dua_pkg::ST_BUSY) && (ones_inc >= dua_pkg::ABORT_ONES)) begin
          abort_nxt = 1'b1;
        end
      end
      case (state_r)
        dua_pkg::ST_READY: begin
          if (bac_sample && !du_s && (ones_r >= need)) begin
            state_nxt = dua_pkg::ST_BUSY;
            abort_nxt = 1'b0;
          end else if (d_sample && (ones_inc >= need)) begin
            state_nxt = dua_pkg::ST_IDLE;
          end
        end
        dua_pkg::ST_IDLE: begin
          // Controller has won the TIC bus and claimed it
          if (bac_sample && !du_s) begin
            state_nxt = dua_pkg::ST_BUSY;
            abort_nxt = 1'b0;
          end
        end
        dua_pkg::ST_BUSY: begin
          // Bus freed: back to stop, level from how the hold ended
          if (bac_sample && du_s) begin
            state_nxt = dua_pkg::ST_READY;
            low_nxt = !abort_r;
            ones_nxt = '0;
          end
        end
        default: begin
          state_nxt = dua_pkg::ST_READY;
        end
      endcase
    end
    // Echo inverted while blocked by the exchange or held from IOM-2
    echo_nxt = arb_en && (!line_permit || (state_nxt == dua_pkg::ST_BUSY));
    // Stop/go: stop whenever blocked, else stop only in Ready
    sg_nxt = !line_permit || (state_nxt == dua_pkg::ST_READY);
  end

  // Arbiter registers; reset to Ready, normal level, normal echo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dua_pkg::ST_READY;
      ones_r <= '0;
      low_r <= 1'b0;
      abort_r <= 1'b0;
      echo_r <= 1'b0;
      sg_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ones_r <= ones_nxt;
      low_r <= low_nxt;
      abort_r <= abort_nxt;
      echo_r <= echo_nxt;
      sg_r <= sg_nxt;
    end
  end

  // Terminals pass through only while no IOM-2 source holds the channel
  assign pass_s = arb_en && s_dchan_active && (state_r != dua_pkg::ST_BUSY) && buf_valid;
  // Pop a word as its second bit goes out
  assign buf_pop = rise && (pos_nxt == dua_pkg::D_POS_LAST) && pass_s;
  assign sg_now = sg_r;

  // Pin drive, changed at rising bit clock edges
  always_comb begin
    du_out_nxt = du_out_r;
    du_oe_n_nxt = du_oe_n_r;
    dd_out_nxt = dd_out_r;
    dd_oe_n_nxt = dd_oe_n_r;
    if (rise) begin
      // Stop/go goes to channel 2 whatever channel is strapped
      if (arb_en && (pos_nxt == dua_pkg::SG_POS)) begin
        dd_out_nxt = sg_now;
        dd_oe_n_nxt = 1'b0;
      end else begin
        dd_out_nxt = 1'b1;
        dd_oe_n_nxt = 1'b1;
      end
      // Wired-or line: only a zero is actively pulled
      if (pass_s && (pos_nxt == dua_pkg::D_POS_FIRST)) begin
        du_out_nxt = buf_data[1];
        du_oe_n_nxt = buf_data[1];
      end else if (pass_s && (pos_nxt == dua_pkg::D_POS_LAST)) begin
        du_out_nxt = buf_data[0];
        du_oe_n_nxt = buf_data[0];
      end else begin
        du_out_nxt = 1'b1;
        du_oe_n_nxt = 1'b1;
      end
    end
    // Disabled arbiter never claims the downstream slot
    if (!arb_en) begin
      dd_out_nxt = 1'b1;
      dd_oe_n_nxt = 1'b1;
    end
  end

  // Pin registers, all released at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      du_out_r <= 1'b1;
      du_oe_n_r <= 1'b1;
      dd_out_r <= 1'b1;
      dd_oe_n_r <= 1'b1;
    end else begin
      du_out_r <= du_out_nxt;
      du_oe_n_r <= du_oe_n_nxt;
      dd_out_r <= dd_out_nxt;
      dd_oe_n_r <= dd_oe_n_nxt;
    end
  end

  // Outputs straight from flops
  assign upstream_data_line_out = du_out_r;
  assign upstream_data_line_oe_n = du_oe_n_r;
  assign downstream_data_line_out = dd_out_r;
  assign downstream_data_line_oe_n = dd_oe_n_r;
  assign echo_invert = echo_r;
  assign stop_go = sg_r;

  // Checks

  property p_zero_restart;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && line_permit && d_sample && !du_s) |=> (ones_r == '0);
  endproperty
  a_zero_restart: assert property (p_zero_restart)
    else $error("ones count not restarted by zero bit");

  property p_go_on_count;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && line_permit && state_r == dua_pkg::ST_READY && !bac_sample
      && d_sample && ones_inc >= need) |=> (state_r == dua_pkg::ST_IDLE) ##1 !sg_r;
  endproperty
  a_go_on_count: assert property (p_go_on_count)
    else $error("stop/go not cleared after n ones");

  property p_grant;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && line_permit && state_r == dua_pkg::ST_IDLE && bac_sample && !du_s)
      |=> (state_r == dua_pkg::ST_BUSY) && echo_r;
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant or echo inversion missing");

  property p_release;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && line_permit && state_r == dua_pkg::ST_BUSY && bac_sample && du_s)
      |=> (state_r == dua_pkg::ST_READY) && sg_r && !echo_r && (low_r == !$past(abort_r));
  endproperty
  a_release: assert property (p_release)
    else $error("release did not restore stop and echo");

  property p_need;
    @(posedge clk) disable iff (!rst_n)
    need == (cfg.iom_access_priority ? (low_r ? 4'hB : 4'hA) : (low_r ? 4'h9 : 4'h8));
  endproperty
  a_need: assert property (p_need)
    else $error("required ones count wrong");

  property p_permit_block;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && !line_permit) |=> echo_r && sg_r && (state_r == dua_pkg::ST_READY);
  endproperty
  a_permit_block: assert property (p_permit_block)
    else $error("permit low did not block sources");

  property p_disabled_quiet;
    @(posedge clk) disable iff (!rst_n)
    !arb_en |=> dd_oe_n_r && !echo_r;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled arbiter drove stop/go or echo");

  property p_sg_slot;
    @(posedge clk) disable iff (!rst_n)
    (arb_en && rise && pos_nxt == dua_pkg::SG_POS) |=> !dd_oe_n_r && (dd_out_r == $past(sg_r));
  endproperty
  a_sg_slot: assert property (p_sg_slot)
    else $error("stop/go slot not driven correctly");

  property p_no_pass_busy;
    @(posedge clk) disable iff (!rst_n)
    (state_r == dua_pkg::ST_BUSY && rise) |=> du_oe_n_r;
  endproperty
  a_no_pass_busy: assert property (p_no_pass_busy)
    else $error("S data passed while IOM source holds channel");

endmodule
`default_nettype wire

// [dua_iom_partner.sv]
// Behavioural far side of the IOM-2 link: bit clock, frame sync, one
// HDLC controller on DU and the pull-ups on DU and DD.
// Assumes the arbiter drives DU and DD open drain with active-low enables.
`timescale 1ns/100ps
`default_nettype none
module dua_iom_partner (
  // Reset
  input wire logic rst_n,
  // Controller requests from the bench
  input wire logic [1:0] ctl_d,
  input wire logic ctl_bac,
  // Arbiter pin drives
  input wire logic du_out,
  input wire logic du_oe_n,
  input wire logic dd_out,
  input wire logic dd_oe_n,
  // Link timing and wire level
  output logic bit_clk,
  output logic fsync,
  output wire logic du_wire,
  // Per-frame observations
  output logic sg_seen,
  output logic sg_drv,
  output logic [1:0] d_seen,
  output int frame_cnt
);
  logic [6:0] pos; // Bit position in the frame
  logic ctl_du; // Controller level, 1 = released
  logic owned; // Controller holds the bus
  logic bac_free; // Bus-accessed bit last seen free
  wire logic dd_wire;
  // Pull-ups: a released line reads 1
  assign du_wire = ctl_du & (du_oe_n | du_out);
  assign dd_wire = dd_oe_n | dd_out;
  // Free-running bit clock, phase unrelated to clk
  initial begin
    {pos, fsync, ctl_du, owned, bac_free} = {7'h5F, 4'hD};
    {sg_seen, sg_drv, d_seen, frame_cnt} = {4'h8, 32'h0};
    bit_clk = 1'h0;
    wait (rst_n === 1'h1);
    #113;
    forever #160 bit_clk = ~bit_clk;
  end
  // Controller changes DU only after a rise
  always @(posedge bit_clk) begin
    pos = (pos == 7'h5F) ? 7'h00 : pos + 7'h01;
    if (pos == 7'h00) frame_cnt = frame_cnt + 1;
    ctl_du = 1'h1;
    if (pos == 7'h18 || pos == 7'h19) begin
      // A claimant sends data only while go is seen and holds ones otherwise
      ctl_du = (!ctl_bac && sg_seen) ? 1'h1 : ctl_d[~pos[0]];
    end else if (pos == 7'h5A) begin
      // Claim only once free was seen; a sole source wins its address
      owned = !ctl_bac && (owned || bac_free);
      ctl_du = !owned;
    end
  end
  // Samples at the fall, frame sync ahead of bit 0
  always @(negedge bit_clk) begin
    fsync = (pos == 7'h5F);
    if (pos == 7'h18 || pos == 7'h19) d_seen = {d_seen[0], du_wire};
    if (pos == 7'h5A) begin
      sg_seen = dd_wire;
      sg_drv = !dd_oe_n;
      bac_free = du_wire;
    end
  end
endmodule
`default_nettype wire

// [dua_arbiter_tb.sv]
// Self-checking bench for the upstream D-channel arbiter.
// Assumes the partner model supplies IOM-2 timing and one controller.
`timescale 1ns/100ps
`default_nettype none
module dua_arbiter_tb;
  // Clock, reset and tallies
  logic clk, rst_n;
  int miscompares, n_compared, cyc;
  // Arbiter inputs
  dua_pkg::dua_cfg_t cfg;
  logic line_permit, s_dchan_active, s_d_valid;
  logic [1:0] s_d_data;
  // Arbiter outputs
  logic du_out, du_oe_n, dd_out, dd_oe_n, s_d_ready, echo_invert, stop_go;
  // Partner side
  logic [1:0] ctl_d, d_seen;
  logic ctl_bac, bit_clk, fsync, sg_seen, sg_drv;
  wire logic du_wire;
  int frame_cnt;

  dua_arbiter #(.FIFO_DEPTH(2)) dua_arbiter_inst (.clk(clk), .rst_n(rst_n), .cfg(cfg),
    .line_permit(line_permit), .bit_clk_pin(bit_clk), .frame_sync_pin(fsync),
    .upstream_data_line_in(du_wire), .upstream_data_line_out(du_out),
    .upstream_data_line_oe_n(du_oe_n), .downstream_data_line_out(dd_out),
    .downstream_data_line_oe_n(dd_oe_n), .s_dchan_active(s_dchan_active),
    .s_d_valid(s_d_valid), .s_d_data(s_d_data), .s_d_ready(s_d_ready),
    .echo_invert(echo_invert), .stop_go(stop_go));
  dua_iom_partner dua_iom_partner_inst (.rst_n(rst_n), .ctl_d(ctl_d), .ctl_bac(ctl_bac),
    .du_out(du_out), .du_oe_n(du_oe_n), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
    .bit_clk(bit_clk), .fsync(fsync), .du_wire(du_wire), .sg_seen(sg_seen),
    .sg_drv(sg_drv), .d_seen(d_seen), .frame_cnt(frame_cnt));

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Hang guard, well above the roughly 65k cycles the run needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One-bit result
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  // Two-bit D word
  task automatic chk_word(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  // Returns just after bit 0 of a later frame
  task automatic wait_frames(input int n);
    int target;
    target = frame_cnt + n;
    while (frame_cnt < target) @(negedge clk);
  endtask
  // Offers one S word and holds it until taken; caller drops valid
  task automatic push(input logic [1:0] w);
    s_d_valid = 1'h1;
    s_d_data = w;
    while (s_d_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
  endtask

  // Levels right after reset
  task automatic check_reset();
    @(negedge clk);
    chk_bit(stop_go, 1'h1);
    chk_bit(echo_invert, 1'h0);
    chk_bit(s_d_ready, 1'h1);
  endtask
  // One grant by ones count, claim, transfer and release
  task automatic run_cycle(input logic prio, input int n, input logic abort);
    int fr_go;
    fr_go = (n + 1) / 2;
    cfg.iom_access_priority = prio;
    ctl_bac = 1'h1;
    ctl_d = 2'h0;
    wait_frames(1);
    ctl_d = 2'h3;
    wait_frames(fr_go - 1);
    chk_bit(stop_go, 1'h1);
    chk_bit(sg_seen, 1'h1);
    wait_frames(1);
    chk_bit(stop_go, 1'h0);
    chk_bit(sg_seen, 1'h0);
    chk_bit(echo_invert, 1'h0);
    ctl_bac = 1'h0;
    wait_frames(1);
    chk_bit(echo_invert, 1'h1);
    ctl_d = abort ? 2'h3 : 2'h1;
    wait_frames(abort ? 4 : 2);
    chk_bit(sg_seen, 1'h0);
    ctl_bac = 1'h1;
    ctl_d = 2'h0;
    wait_frames(1);
    chk_bit(stop_go, 1'h1);
    chk_bit(echo_invert, 1'h0);
  endtask
  // Exchange withholds and then grants permission
  task automatic check_permit();
    ctl_d = 2'h3;
    line_permit = 1'h0;
    repeat (4) @(negedge clk);
    chk_bit(echo_invert, 1'h1);
    chk_bit(stop_go, 1'h1);
    wait_frames(5);
    chk_bit(stop_go, 1'h1);
    ctl_bac = 1'h0;
    wait_frames(2);
    chk_bit(sg_seen, 1'h1);
    chk_bit(echo_invert, 1'h1);
    line_permit = 1'h1;
    ctl_bac = 1'h1;
    wait_frames(5);
    chk_bit(stop_go, 1'h0);
    chk_bit(echo_invert, 1'h0);
  endtask
  // S words fill the buffer, then appear in channel 0 in order
  task automatic check_passthrough();
    s_dchan_active = 1'h1;
    wait_frames(1);
    push(2'h2);
    push(2'h1);
    chk_bit(s_d_ready, 1'h0);
    push(2'h0);
    s_d_valid = 1'h0;
    wait_frames(1);
    chk_word(d_seen, 2'h2);
    wait_frames(1);
    chk_word(d_seen, 2'h1);
    wait_frames(1);
    chk_word(d_seen, 2'h0);
    s_dchan_active = 1'h0;
  endtask
  // Each wrong setting keeps the arbiter out; the last one enables it
  task automatic check_config();
    dua_pkg::dua_cfg_t tab [5];
    tab[0] = '{3'h3, 3'h1, 1'h1, 1'h1, 1'h0};
    tab[1] = '{3'h6, 3'h0, 1'h1, 1'h1, 1'h0};
    tab[2] = '{3'h6, 3'h1, 1'h0, 1'h1, 1'h0};
    tab[3] = '{3'h6, 3'h1, 1'h1, 1'h0, 1'h0};
    tab[4] = '{3'h7, 3'h1, 1'h1, 1'h1, 1'h0};
    for (int i = 0; i < 5; i++) begin
      cfg = tab[i];
      ctl_d = 2'h0;
      wait_frames(1);
      ctl_d = 2'h3;
      wait_frames(4);
      chk_bit(stop_go, i < 4);
      chk_bit(sg_drv, i == 4);
    end
  endtask

  // Main sequence
  initial begin
    {miscompares, n_compared, cyc} = '0;
    cfg = '{3'h6, 3'h1, 1'h1, 1'h1, 1'h0};
    {rst_n, line_permit, s_dchan_active, s_d_valid, s_d_data} = 6'h10;
    ctl_d = 2'h3;
    ctl_bac = 1'h1;
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    check_reset();
    run_cycle(1'h0, 8, 1'h0);
    run_cycle(1'h0, 9, 1'h1);
    run_cycle(1'h1, 10, 1'h0);
    run_cycle(1'h1, 11, 1'h1);
    check_permit();
    check_passthrough();
    check_config();
    end_of_test();
  end
endmodule
`default_nettype wire
